// ==== dccr_top.sv ====
// Mode control and clear-value registers behind the serial link.
//
// Functional notes
// - Clear request loads clear-value code to output.
// - Clear value follows selected data coding format.
// - Clear-value register resets to zero.
// - Feedback bit 0: amplifier on, resistors series.
// - Feedback bit 1 default: amplifier off, parallel.
// - Clamp bit 0: clamp released, normal operation.
// - Clamp bit 1 default: clamp and tristate.
// - Reset returns output to clamped, tristated state.
// - Clamp set overrules converter tristate bit.
// - Tristate bit 3, one means tristate, default one.
// - Format bit 4: 0 twos complement, 1 binary.
// - Bit 5 one places serial output high impedance.
// - Frame top bit selects write or read.
// - Address 010 writes or reads mode control.
// - Read data shifts out over next 24 clocks.
`timescale 1ns/100ps
module dccr_top
    import dccr_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        link_clk,
    input  wire logic        frame_sel_n,
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    output logic             serial_data_out_oe,
    input  wire logic        clear_request_n,
    input  wire logic        sw_clear,
    output logic             internal_amplifier_on,
    output logic             feedback_parallel,
    output logic             output_ground_clamp,
    output logic             converter_tristate,
    output logic             code_format_select,
    output logic [15:0]      clear_code_obin,
    output logic             clear_active
);
    `include "dccr_params.svh"

    // ------------------------------------------------------------------
    // Link logic and crossings
    // ------------------------------------------------------------------
    dccr_xfer_if xfer ();  // Carries frame, toggles and readback word.

    // The link side runs only while the host clocks a frame.
    dccr_link u_link (
        .link_clk           (link_clk),
        .rst_n              (rst_n),
        .frame_sel_n        (frame_sel_n),
        .serial_data_in     (serial_data_in),
        .serial_data_out    (serial_data_out),
        .serial_data_out_oe (serial_data_out_oe),
        .xfer               (xfer.link)
    );

    logic [3:0] raw_lvls;   // Frame select, clear pin and two toggles.
    logic [3:0] sync_lvls;  // Same levels after two core flip-flops.

    assign raw_lvls = {~frame_sel_n, ~clear_request_n,
                       xfer.done_tog, xfer.over_tog};

    // Pins and link-domain toggles pass two flops before any use.
    // Inverted pins make the reset value read as idle.
    dccr_sync #(.W(4)) u_sync (
        .clk      (core_clk),
        .rst_n    (rst_n),
        .async_in (raw_lvls),
        .sync_out (sync_lvls)
    );

    logic frame_act_s;  // Frame select low, synchronised.
    logic clear_pin_s;  // Clear pin low, synchronised.
    logic done_s;       // Completion toggle, synchronised.
    logic over_s;       // Overrun toggle, synchronised.

    assign frame_act_s = sync_lvls[3];
    assign clear_pin_s = sync_lvls[2];
    assign done_s      = sync_lvls[1];
    assign over_s      = sync_lvls[0];

    // ------------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------------
    logic        frame_act_q;   // Previous frame-active level.
    logic        done_seen_q;   // Last completion toggle value seen.
    logic        over_seen_q;   // Last overrun toggle value seen.
    logic        got24_q;       // 24th edge seen in the current frame.
    logic        got25_q;       // More than 24 edges seen in it.
    logic        primed_q;      // Toggle copies primed after reset.
    dccr_state_t state_q;       // Commit sequencer state.
    logic [1:0]  settle_q;      // Settle cycle counter.
    logic        frame_act_d;
    logic        done_seen_d;
    logic        over_seen_d;
    logic        got24_d;
    logic        got25_d;
    logic        primed_d;
    dccr_state_t state_d;
    logic [1:0]  settle_d;
    logic        commit;        // One-cycle pulse: apply the frame.

    // Next values: note toggle edges, wait after frame end so the
    // last toggle has crossed, then commit only an exact 24-bit frame.
    always_comb begin
        frame_act_d = frame_act_s;
        done_seen_d = done_s;
        over_seen_d = over_s;
        primed_d    = 1'b1;
        got24_d     = got24_q;
        got25_d     = got25_q;
        state_d     = state_q;
        settle_d    = settle_q;
        commit      = 1'b0;
        if (primed_q && (done_s != done_seen_q)) begin
            got24_d = 1'b1;
        end
        if (primed_q && (over_s != over_seen_q)) begin
            got25_d = 1'b1;
        end
        case (state_q)
            DCCR_ST_IDLE: begin
                if (frame_act_q && !frame_act_s) begin
                    state_d  = DCCR_ST_SETTLE;
                    settle_d = `DCCR_SETTLE_CYC;
                end
            end
            DCCR_ST_SETTLE: begin
                settle_d = settle_q - 2'h1;
                if (settle_q == 2'h1) begin
                    state_d = DCCR_ST_COMMIT;
                end
            end
            DCCR_ST_COMMIT: begin
                commit  = got24_q && !got25_q;
                got24_d = 1'b0;
                got25_d = 1'b0;
                state_d = DCCR_ST_IDLE;
            end
            default: begin
                state_d = DCCR_ST_IDLE;
            end
        endcase
    end

    // Register the frame tracker.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_act_q <= 1'b0;
            done_seen_q <= 1'b0;
            over_seen_q <= 1'b0;
            got24_q     <= 1'b0;
            got25_q     <= 1'b0;
            primed_q    <= 1'b0;
            state_q     <= DCCR_ST_IDLE;
            settle_q    <= 2'h0;
        end else begin
            frame_act_q <= frame_act_d;
            done_seen_q <= done_seen_d;
            over_seen_q <= over_seen_d;
            got24_q     <= got24_d;
            got25_q     <= got25_d;
            primed_q    <= primed_d;
            state_q     <= state_d;
            settle_q    <= settle_d;
        end
    end

    // ------------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------------
    logic        fr_read;   // Top bit set: read request.
    logic [2:0]  fr_addr;   // Register address field.
    logic [15:0] fr_code;   // Clear-value data field.

    assign fr_read = xfer.frame_word[`DCCR_RW_POS];
    assign fr_addr = xfer.frame_word[`DCCR_ADDR_MSB:`DCCR_ADDR_LSB];
    assign fr_code = xfer.frame_word[`DCCR_CODE_MSB:`DCCR_CODE_LSB];

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    dccr_mode_t  mode_q;    // The mode_control register fields.
    dccr_mode_t  mode_d;
    logic [15:0] clear_q;   // Clear-value register.
    logic [15:0] clear_d;
    logic [23:0] rd_word_q; // Word shifted out in the next frame.
    logic [23:0] rd_word_d;
    logic        rd_arm_q;  // Next frame carries readback data.
    logic        rd_arm_d;

    // Next values: writes update a register; reads prepare a word with
    // each field at its write position. Reserved bits are not stored,
    // so they read back as zero whatever the host wrote.
    always_comb begin
        mode_d    = mode_q;
        clear_d   = clear_q;
        rd_word_d = rd_word_q;
        rd_arm_d  = rd_arm_q;
        if (commit) begin
            rd_arm_d  = fr_read;
            rd_word_d = {fr_read, fr_addr, 20'h00000};
            if (!fr_read && fr_addr == `DCCR_ADDR_CTRL) begin
                mode_d.amp_feedback_select =
                    xfer.frame_word[`DCCR_FB_POS];
                mode_d.output_ground_clamp =
                    xfer.frame_word[`DCCR_CLAMP_POS];
                mode_d.converter_tristate =
                    xfer.frame_word[`DCCR_TRI_POS];
                mode_d.code_format_select =
                    xfer.frame_word[`DCCR_FMT_POS];
                mode_d.serial_out_disable =
                    xfer.frame_word[`DCCR_SERIAL_OUT_DISABLE_POS];
            end
            if (!fr_read && fr_addr == `DCCR_ADDR_CLEAR) begin
                clear_d = fr_code;
            end
            if (fr_read && fr_addr == `DCCR_ADDR_CTRL) begin
                rd_word_d[`DCCR_FB_POS]     = mode_q.amp_feedback_select;
                rd_word_d[`DCCR_CLAMP_POS]  = mode_q.output_ground_clamp;
                rd_word_d[`DCCR_TRI_POS]    = mode_q.converter_tristate;
                rd_word_d[`DCCR_FMT_POS]    = mode_q.code_format_select;
                rd_word_d[`DCCR_SERIAL_OUT_DISABLE_POS] = mode_q.serial_out_disable;
            end
            if (fr_read && fr_addr == `DCCR_ADDR_CLEAR) begin
                rd_word_d[`DCCR_CODE_MSB:`DCCR_CODE_LSB] = clear_q;
            end
        end
    end

    // Reset puts the output in the clamped, tristated state.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q.amp_feedback_select <= `DCCR_FB_RST;
            mode_q.output_ground_clamp <= `DCCR_CLAMP_RST;
            mode_q.converter_tristate  <= `DCCR_TRI_RST;
            mode_q.code_format_select  <= `DCCR_FMT_RST;
            mode_q.serial_out_disable  <= `DCCR_SERIAL_OUT_DISABLE_RST;
            clear_q                    <= `DCCR_CLEAR_RST;
            rd_word_q                  <= 24'h000000;
            rd_arm_q                   <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            clear_q   <= clear_d;
            rd_word_q <= rd_word_d;
            rd_arm_q  <= rd_arm_d;
        end
    end

    // The link reads these only while a frame is clocked; the host must
    // leave a gap after frame end for the commit to settle.
    assign xfer.rd_word = rd_word_q;
    assign xfer.rd_arm  = rd_arm_q;
    assign xfer.sdo_dis = mode_q.serial_out_disable;

    // ------------------------------------------------------------------
    // Clear path
    // ------------------------------------------------------------------
    logic [15:0] clear_obin_q;  // Clear code in offset binary.
    logic [15:0] clear_obin_d;
    logic        clear_act_q;   // Output held at the clear code.
    logic        clear_act_d;

    // Next values: either request loads the clear code; twos complement
    // codes are turned to offset binary by flipping the sign bit. The
    // held level ends only with a reset, since data writes are not part
    // of this block.
    always_comb begin
        clear_obin_d = clear_obin_q;
        clear_act_d  = clear_act_q;
        if (clear_pin_s || sw_clear) begin
            clear_act_d = 1'b1;
            if (mode_q.code_format_select) begin
                clear_obin_d = clear_q;
            end else begin
                clear_obin_d = clear_q ^ `DCCR_SIGN_FLIP;
            end
        end
    end

    // Register the clear path.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clear_obin_q <= 16'h0000;
            clear_act_q  <= 1'b0;
        end else begin
            clear_obin_q <= clear_obin_d;
            clear_act_q  <= clear_act_d;
        end
    end

    // ------------------------------------------------------------------
    // Analog control outputs
    // ------------------------------------------------------------------
    // Feedback select 0 powers the amplifier with series resistors,
    // 1 powers it down with parallel resistors.
    assign internal_amplifier_on = ~mode_q.amp_feedback_select;
    assign feedback_parallel     = mode_q.amp_feedback_select;
    // Clamp set forces tristate whatever the tristate bit holds.
    assign output_ground_clamp   = mode_q.output_ground_clamp;
    assign converter_tristate    = mode_q.output_ground_clamp |
                                   mode_q.converter_tristate;
    assign code_format_select    = mode_q.code_format_select;
    assign clear_code_obin       = clear_obin_q;
    assign clear_active          = clear_act_q;
endmodule

// ==== dccr_params.svh ====
// Field positions, frame codes, reset values and timing counts for the block.
`ifndef DCCR_PARAMS_SVH
`define DCCR_PARAMS_SVH

// ----------------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------------
`define DCCR_FRAME_BITS      24
`define DCCR_RW_POS          23
`define DCCR_ADDR_MSB        22
`define DCCR_ADDR_LSB        20
`define DCCR_CODE_MSB        19
`define DCCR_CODE_LSB        4

// ----------------------------------------------------------------------
// Register address codes
// ----------------------------------------------------------------------
`define DCCR_ADDR_DAC        3'h1
`define DCCR_ADDR_CTRL       3'h2
`define DCCR_ADDR_CLEAR      3'h3

// ----------------------------------------------------------------------
// Mode control field positions
// ----------------------------------------------------------------------
`define DCCR_FB_POS          1
`define DCCR_CLAMP_POS       2
`define DCCR_TRI_POS         3
`define DCCR_FMT_POS         4
`define DCCR_SERIAL_OUT_DISABLE_POS      5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DCCR_FB_RST          1'b1
`define DCCR_CLAMP_RST       1'b1
`define DCCR_TRI_RST         1'b1
`define DCCR_FMT_RST         1'b0
`define DCCR_SERIAL_OUT_DISABLE_RST      1'b0
`define DCCR_CLEAR_RST       16'h0000
`define DCCR_SIGN_FLIP       16'h8000

// ----------------------------------------------------------------------
// Timing: core cycles waited after frame end before commit
// ----------------------------------------------------------------------
`define DCCR_SETTLE_CYC      2'h2

`endif

// ==== dccr_pkg.sv ====
// Types shared by the control and clear-value register block.
package dccr_pkg;

    // Commit sequencer states of the core domain.
    typedef enum logic [1:0] {
        DCCR_ST_IDLE   = 2'b00,
        DCCR_ST_SETTLE = 2'b01,
        DCCR_ST_COMMIT = 2'b10
    } dccr_state_t;

    // Mode control fields as held in the core.
    typedef struct packed {
        logic serial_out_disable;
        logic code_format_select;
        logic converter_tristate;
        logic output_ground_clamp;
        logic amp_feedback_select;
    } dccr_mode_t;

endpackage

// ==== dccr_xfer_if.sv ====
// Signals passed between the link-clock logic and the core logic.
`timescale 1ns/100ps
interface dccr_xfer_if;
    logic [23:0] frame_word;  // Last complete 24-bit frame, link domain.
    logic        done_tog;    // Toggles at the 24th falling clock edge.
    logic        over_tog;    // Toggles at the 25th falling clock edge.
    logic [23:0] rd_word;     // Readback word, core domain, quasi-static.
    logic        rd_arm;      // Readback armed for the next frame.
    logic        sdo_dis;     // Serial output disable level, core domain.

    modport link (
        output frame_word,
        output done_tog,
        output over_tog,
        input  rd_word,
        input  rd_arm,
        input  sdo_dis
    );

    modport core (
        input  frame_word,
        input  done_tog,
        input  over_tog,
        output rd_word,
        output rd_arm,
        output sdo_dis
    );
endinterface

// ==== dccr_sync.sv ====
// Two flip-flop level synchroniser of parameterised width.
`timescale 1ns/100ps
module dccr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    // ------------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------------
    logic [W-1:0] meta_q;  // First stage, read only by the second stage.
    logic [W-1:0] meta_d;  // Next value of the first stage.
    logic [W-1:0] sync_q;  // Second stage, safe to use.
    logic [W-1:0] sync_d;  // Next value of the second stage.

    // Next values: plain shift through the two stages.
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Both stages clear to zero; callers pick the sense accordingly.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

// ==== dccr_link.sv ====
// Serial link logic clocked by the host's serial clock.
`timescale 1ns/100ps
module dccr_link
    import dccr_pkg::*;
(
    input  wire logic   link_clk,
    input  wire logic   rst_n,
    input  wire logic   frame_sel_n,
    input  wire logic   serial_data_in,
    output logic        serial_data_out,
    output logic        serial_data_out_oe,
    dccr_xfer_if.link   xfer
);
    `include "dccr_params.svh"

    // ------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------
    logic [4:0]  bit_cnt_q;    // Falling edges seen in this frame, saturates.
    logic [4:0]  bit_cnt_d;
    logic [23:0] shift_q;      // Incoming bits, MSB first.
    logic [23:0] shift_d;
    logic [23:0] word_q;       // Frame captured at the 24th edge.
    logic [23:0] word_d;
    logic        done_q;
    logic        done_d;
    logic        over_q;
    logic        over_d;

    // Next values: count edges and shift in; capture at exactly 24.
    always_comb begin
        bit_cnt_d = bit_cnt_q;
        shift_d   = {shift_q[22:0], serial_data_in};
        word_d    = word_q;
        done_d    = done_q;
        over_d    = over_q;
        if (bit_cnt_q != 5'd25) begin
            bit_cnt_d = bit_cnt_q + 5'd1;
        end
        if (bit_cnt_q == 5'd23) begin
            word_d = {shift_q[22:0], serial_data_in};
            done_d = ~done_q;
        end
        if (bit_cnt_q == 5'd24) begin
            over_d = ~over_q;  // The core discards the frame.
        end
    end

    // The counter is cleared by the frame signal itself, because the
    // serial clock may stop as soon as the frame ends.
    always_ff @(negedge link_clk or posedge frame_sel_n) begin
        if (frame_sel_n) begin
            bit_cnt_q <= 5'd0;
        end else begin
            bit_cnt_q <= bit_cnt_d;
        end
    end

    // Data flops carry no reset: they are only read after a toggle.
    always_ff @(negedge link_clk) begin
        shift_q <= shift_d;
        word_q  <= word_d;
    end

    // Toggles reset with the core, so both sides start at the same level;
    // an unknown toggle would stay unknown and no frame would ever commit.
    always_ff @(negedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            over_q <= 1'b0;
        end else begin
            done_q <= done_d;
            over_q <= over_d;
        end
    end

    assign xfer.frame_word = word_q;
    assign xfer.done_tog   = done_q;
    assign xfer.over_tog   = over_q;

    // ------------------------------------------------------------------
    // Readback output
    // ------------------------------------------------------------------
    // The readback word and arm level change only between frames, so
    // they are steady whenever the serial clock runs.
    always_comb begin
        serial_data_out = 1'b0;
        if (bit_cnt_q < 5'd24) begin
            serial_data_out = xfer.rd_word[5'd23 - bit_cnt_q];
        end
    end

    // Driven only inside a frame, when armed and not disabled.
    assign serial_data_out_oe = ~frame_sel_n & xfer.rd_arm & ~xfer.sdo_dis;
endmodule

// ==== dccr_top_asserts.sv ====
// Concurrent checks on the ports of the register block.
`timescale 1ns/100ps
module dccr_top_asserts
    import dccr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic frame_sel_n,
    input wire logic serial_data_out_oe,
    input wire logic clear_request_n,
    input wire logic sw_clear,
    input wire logic internal_amplifier_on,
    input wire logic feedback_parallel,
    input wire logic output_ground_clamp,
    input wire logic converter_tristate,
    input wire logic code_format_select,
    input wire logic clear_active
);
    // ------------------------------------------------------------------
    // All checks live in the core domain and sleep during reset.
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_amp_vs_fb: assert property (
        internal_amplifier_on == !feedback_parallel)
        else $error("amplifier enable does not mirror feedback select");
    a_clamp_over_tri: assert property (
        output_ground_clamp |-> converter_tristate)
        else $error("clamped output not tristated");
    a_reset_state: assert property (
        $rose(rst_n) |-> output_ground_clamp && converter_tristate &&
        feedback_parallel && !code_format_select)
        else $error("wrong mode after reset release");
    a_oe_in_frame: assert property (
        serial_data_out_oe |-> !frame_sel_n)
        else $error("serial output driven outside a frame");
    a_clear_holds: assert property (clear_active |=> clear_active)
        else $error("clear state dropped without reset");
    a_sw_clear: assert property (sw_clear |=> clear_active)
        else $error("software clear not taken");
    a_pin_clear: assert property (
        (!clear_request_n) [*4] |-> clear_active)
        else $error("clear pin not taken within three cycles");
    a_write_quiet: assert property (
        $changed(code_format_select) |-> $past(frame_sel_n, 3))
        else $error("mode changed while a frame was running");

    // A read, a mode write and a clear must all be exercised.
    c_readback: cover property (serial_data_out_oe);
    c_mode_write: cover property ($changed(output_ground_clamp));
    c_clear: cover property (sw_clear ##1 clear_active);
endmodule

// ==== dccr_host_model.sv ====
// Host serial controller model driving frame select and link clock.
`timescale 1ns/100ps
module dccr_host_model (
    output logic      link_clk,
    output logic      frame_sel_n,
    output logic      serial_data_in,
    input  wire logic serial_data_out,
    input  wire logic serial_data_out_oe
);
    logic last_bit;  // Last bit seen, inverted while the line floats.

    // The link clock idles high and stands still outside frames.
    initial begin
        link_clk = 1'b1;
        frame_sel_n = 1'b1;
        serial_data_in = 1'b0;
        last_bit = 1'b0;
    end

    // ------------------------------------------------------------------
    // One frame of exactly 24 falling edges, MSB first.
    // ------------------------------------------------------------------
    task automatic xfer(input logic [23:0] w, output logic [23:0] r,
                        output logic oe);
        oe = 1'b0;
        #1.7 frame_sel_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            serial_data_in = w[i];
            #3;
            oe |= serial_data_out_oe;
            r[i] = serial_data_out_oe ? serial_data_out : ~last_bit;
            last_bit = r[i];
            link_clk = 1'b0;
            #3;
            link_clk = 1'b1;
        end
        #3 frame_sel_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #100;  // Gap well above ten core cycles between frames.
    endtask
endmodule

// ==== tb.sv ====
// Self-checking testbench for the mode control and clear-value block.
`timescale 1ns/100ps
module tb;
    import dccr_pkg::*;
    logic        core_clk, rst_n, clear_request_n, sw_clear, oe_seen;
    logic        link_clk, frame_sel_n, serial_data_in;
    logic        serial_data_out, serial_data_out_oe, clear_active;
    logic        internal_amplifier_on, feedback_parallel;
    logic        output_ground_clamp, converter_tristate, code_format_select;
    logic [15:0] clear_code_obin;
    logic [23:0] rd;
    int          n_errors = 0;
    int          check_count = 0;

    dccr_top u_dccr_top (.core_clk(core_clk), .rst_n(rst_n),
        .link_clk(link_clk), .frame_sel_n(frame_sel_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe),
        .clear_request_n(clear_request_n), .sw_clear(sw_clear),
        .internal_amplifier_on(internal_amplifier_on),
        .feedback_parallel(feedback_parallel),
        .output_ground_clamp(output_ground_clamp),
        .converter_tristate(converter_tristate),
        .code_format_select(code_format_select),
        .clear_code_obin(clear_code_obin), .clear_active(clear_active));
    dccr_host_model u_dccr_host_model (.link_clk(link_clk),
        .frame_sel_n(frame_sel_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe));

    // Core clock at 125 MHz.
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // Shared helpers.
    // ------------------------------------------------------------------
    task automatic chk(input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // Mode outputs as {amp_on, fb, clamp, tri, format}.
    function automatic logic [23:0] mode();
        return {internal_amplifier_on, feedback_parallel,
                output_ground_clamp, converter_tristate, code_format_select};
    endfunction
    task automatic wr(input logic [23:0] w);
        u_dccr_host_model.xfer(w, rd, oe_seen);
        @(negedge core_clk);
    endtask
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_reset;
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        chk(5'b01110, mode());
        chk(1'b0, serial_data_out_oe);
    endtask
    // Clear by bit and by pin, in both coding formats.
    task automatic t_clear;
        sw_clear = 1'b1;
        @(negedge core_clk);
        sw_clear = 1'b0;
        chk(16'h8000, clear_code_obin);
        chk(1'b1, clear_active);
        wr(24'h312340);
        sw_clear = 1'b1;
        @(negedge core_clk);
        sw_clear = 1'b0;
        chk(16'h9234, clear_code_obin);
        wr(24'h200010);
        clear_request_n = 1'b0;
        repeat (4) @(negedge core_clk);
        clear_request_n = 1'b1;
        chk(16'h1234, clear_code_obin);
    endtask
    task automatic t_ctrl;
        wr(24'h200018);
        chk(5'b10011, mode());
        wr(24'h200004);
        chk(5'b10110, mode());
        wr(24'h200002);
        chk(5'b01000, mode());
    endtask
    // Read-flagged frame must not write; readback then output disable.
    task automatic t_read;
        wr(24'h200012);
        wr(24'ha0001c);
        chk(5'b01001, mode());
        wr(24'h000000);
        chk(24'ha00012, rd);
        chk(1'b1, oe_seen);
        wr(24'h200032);
        wr(24'ha00000);
        wr(24'h000000);
        chk(1'b0, oe_seen);
    endtask

    // Watchdog: the whole run needs well under 10 us.
    initial begin
        #50000;
        n_errors++;
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        clear_request_n = 1'b1;
        sw_clear = 1'b0;
        t_reset();
        t_clear();
        t_ctrl();
        t_read();
        t_reset();
        end_of_test();
    end
endmodule

bind dccr_top dccr_top_asserts u_dccr_top_asserts (.*);
